// >>> src/cfr_pkg.sv
// Package with types, encodings and constants for the fetch/read sequencer
// Overview of operation
// - Drive cycle-type status at cycle start
// - Select line marks memory or port
// - First status line marks read/write
// - Fetch encodes select 0, status 1,1
// - Present 16-bit address; fetch uses PC
// - High address byte stable through T4 start
// - Low address driven one clock in T1
// - After T1 float low lines on reads
// - Pulse address latch strobe in T1
// - Assert read strobe after address float
// - Capture opcode in T3, release strobe
// - First machine cycle goes T3 to T4
// - T4 decodes: T5/T6 or new T1
// - Fetch is four states, six for decrement
// - High address may change T4 to T6
// - Sample ready in T2; wait when low
// - Wait states hold T2 outputs unchanged
// - Memory read encodes 0,1,0; same timing
// - Other cycles go T3 to next T1
// - State changes on falling clock edge
package cfr_pkg;

  // ------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    CFR_T1,
    CFR_T2,
    CFR_WAIT,
    CFR_T3,
    CFR_T4,
    CFR_T5,
    CFR_T6
  } cfr_state_t;

  // ------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------
  localparam int CFR_AW = 16;
  localparam int CFR_DW = 8;
  localparam logic [15:0] CFR_PC_RST = 16'h0000;
  localparam logic [7:0] CFR_BYTE_RST = 8'h00;
  // Opcode byte that selects the six-state fetch (pair decrement)
  localparam logic [7:0] CFR_DEC_MASK = 8'hCF;
  localparam logic [7:0] CFR_DEC_CODE = 8'h0B;
  localparam logic [15:0] CFR_ONE = 16'h0001;

  // ------------------------------------------------------------
  // Status encodings {select, status_read_write, status_fetch_qual}
  // ------------------------------------------------------------
  localparam logic [2:0] CFR_ST_FETCH = 3'h3;
  localparam logic [2:0] CFR_ST_MREAD = 3'h2;
  localparam logic [2:0] CFR_ST_IDLE = 3'h2;

  // Status bundle driven on the pins
  typedef struct packed {
    logic io_select;
    logic status_read_write;
    logic status_fetch_qual;
  } cfr_status_t;

  // Bus pin bundle
  typedef struct packed {
    logic [7:0] addr_high_byte;
    logic [7:0] muxed_addr_data_low;
    logic low_oe_n;
    logic addr_latch_en;
    logic read_n;
  } cfr_bus_t;

endpackage

// >>> src/cfr_opcode_decode.sv
// Opcode decoder choosing the four- or six-state fetch
`timescale 1ns/1ps
module cfr_opcode_decode (
  input wire logic [7:0] opcode,
  output logic pair_decrement_instr,
  output logic [1:0] pair_sel
);
  import cfr_pkg::*;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  // Register-pair decrement class: pair number sits in bits 5:4
  always_comb begin
    pair_decrement_instr = ((opcode & CFR_DEC_MASK) == CFR_DEC_CODE);
    pair_sel = opcode[5:4];
  end
endmodule

// >>> src/cfr_fetch_read_seq.sv
// Fetch and memory-read bus cycle sequencer on a multiplexed bus
`timescale 1ns/1ps
module cfr_fetch_read_seq (
  input wire logic clock,
  input wire logic rst,
  input wire logic ready,
  input wire logic [7:0] muxed_data_in,
  input wire logic read_req,
  input wire logic [15:0] read_addr,
  output cfr_pkg::cfr_status_t status,
  output logic [7:0] addr_high_byte,
  output logic [7:0] muxed_addr_data_low,
  output logic low_oe_n,
  output logic addr_latch_en,
  output logic read_n,
  output logic [7:0] opcode_out,
  output logic opcode_valid,
  output logic [7:0] read_data,
  output logic read_data_valid,
  output logic first_machine_cycle,
  output logic [15:0] pair_value,
  output cfr_pkg::cfr_state_t state_out
);
  import cfr_pkg::*;

  // ------------------------------------------------------------
  // State and registers
  // ------------------------------------------------------------
  cfr_state_t state_reg, state_next;           // T-state
  logic fetch_reg, fetch_next;                 // Current cycle is a fetch
  logic [15:0] pc_reg, pc_next;                // Program counter
  logic [15:0] addr_reg, addr_next;            // Address of this cycle
  logic [7:0] ir_reg, ir_next;                 // Instruction register
  logic [7:0] rdat_reg, rdat_next;             // Memory read result
  logic opv_reg, opv_next;                     // Opcode capture pulse
  logic rdv_reg, rdv_next;                     // Read data pulse
  logic dec_reg, dec_next;                     // Six-state fetch chosen
  logic [1:0] psel_reg, psel_next;             // Pair being decremented
  logic [15:0] pair_reg [4];                   // Register pairs
  logic [15:0] pair_next [4];
  cfr_status_t st_reg, st_next;                // Status pins
  cfr_bus_t bus_reg, bus_next;                 // Bus pins
  logic pend_reg, pend_next;                   // A memory read is queued
  logic [15:0] paddr_reg, paddr_next;          // Queued read address
  logic dec_hit;                               // Decoder output
  logic [1:0] dec_pair;
  logic [15:0] pval_reg, pval_next;            // Pair shown on the pins

  // Captured byte feeds decode directly so T4 can branch on it
  cfr_opcode_decode i_cfr_opcode_decode (
    .opcode(ir_reg),
    .pair_decrement_instr(dec_hit),
    .pair_sel(dec_pair)
  );

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  // One process computes every next value from the current state
  always_comb begin
    state_next = state_reg;
    fetch_next = fetch_reg;
    pc_next = pc_reg;
    addr_next = addr_reg;
    ir_next = ir_reg;
    rdat_next = rdat_reg;
    opv_next = 1'b0;
    rdv_next = 1'b0;
    dec_next = dec_reg;
    psel_next = psel_reg;
    pair_next = pair_reg;
    st_next = st_reg;
    bus_next = bus_reg;
    pend_next = pend_reg;
    paddr_next = paddr_reg;
    // Requests are queued; one arriving while a read is already pending is dropped
    if (read_req && !pend_reg) begin
      pend_next = 1'b1;
      paddr_next = read_addr;
    end
    case (state_reg)
      CFR_T1: begin
        // Address low byte floats after its one clock
        bus_next.low_oe_n = 1'b1;
        bus_next.addr_latch_en = 1'b0;
        // Read strobe falls once the low drivers are off
        bus_next.read_n = 1'b0;
        state_next = CFR_T2;
      end
      CFR_T2, CFR_WAIT: begin
        // Ready is looked at in T2 and each wait state
        if (ready) begin
          state_next = CFR_T3;
        end else begin
          // Pins keep their T2 values while waiting
          state_next = CFR_WAIT;
        end
      end
      CFR_T3: begin
        // Strobe rises after the data byte is taken
        bus_next.read_n = 1'b1;
        if (fetch_reg) begin
          ir_next = muxed_data_in;
          opv_next = 1'b1;
          pc_next = pc_reg + CFR_ONE;
          // The first machine cycle always continues to T4
          state_next = CFR_T4;
          st_next = CFR_ST_IDLE;
        end else begin
          rdat_next = muxed_data_in;
          rdv_next = 1'b1;
          // Non-fetch cycles go straight to the next T1
          state_next = CFR_T1;
          fetch_next = 1'b1;
          addr_next = pc_reg;
          st_next = CFR_ST_FETCH;
          bus_next.addr_high_byte = pc_reg[15:8];
          bus_next.muxed_addr_data_low = pc_reg[7:0];
          bus_next.low_oe_n = 1'b0;
          bus_next.addr_latch_en = 1'b1;
        end
      end
      CFR_T4: begin
        // Decide between six-state and four-state fetch
        if (dec_hit) begin
          dec_next = 1'b1;
          psel_next = dec_pair;
          state_next = CFR_T5;
          // High byte follows the incrementer latch
          bus_next.addr_high_byte = pc_reg[15:8];
        end else begin
          dec_next = 1'b0;
          state_next = CFR_T1;
        end
      end
      CFR_T5: begin
        // Decrement spans T5 and T6; result written in T5
        pair_next[psel_reg] = pair_reg[psel_reg] - CFR_ONE;
        state_next = CFR_T6;
      end
      CFR_T6: begin
        state_next = CFR_T1;
      end
      default: begin
        state_next = CFR_T1;
      end
    endcase
    // Start of a new cycle from T4 or T6: status and address
    if ((state_reg == CFR_T6) ||
        (state_reg == CFR_T4 && !dec_hit)) begin
      if (pend_reg) begin
        // Memory read: same T1-T3 timing, qualifier low
        fetch_next = 1'b0;
        addr_next = paddr_reg;
        st_next = CFR_ST_MREAD;
        pend_next = 1'b0;
      end else begin
        fetch_next = 1'b1;
        addr_next = pc_reg;
        st_next = CFR_ST_FETCH;
      end
      // Full 16-bit address; high byte held through T4
      bus_next.addr_high_byte = pend_reg ? paddr_reg[15:8] : pc_reg[15:8];
      bus_next.muxed_addr_data_low =
        pend_reg ? paddr_reg[7:0] : pc_reg[7:0];
      bus_next.low_oe_n = 1'b0;
      bus_next.addr_latch_en = 1'b1;
    end
    // Pin copy of the chosen pair, so the output is a plain register
    pval_next = pair_next[psel_next];
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // The pin clock is taken as the falling edge of the processor
  // clock: this block's clock input is that edge
  always_ff @(posedge clock) begin
    if (rst) begin
      // Fetch T1 at PC zero, read strobe idle, latch strobe high
      state_reg <= CFR_T1;
      fetch_reg <= 1'b1;
      pc_reg <= CFR_PC_RST;
      addr_reg <= CFR_PC_RST;
      ir_reg <= CFR_BYTE_RST;
      rdat_reg <= CFR_BYTE_RST;
      opv_reg <= 1'b0;
      rdv_reg <= 1'b0;
      dec_reg <= 1'b0;
      psel_reg <= 2'h0;
      for (int i = 0; i < 4; i++) begin
        pair_reg[i] <= CFR_PC_RST;
      end
      st_reg <= CFR_ST_FETCH;
      bus_reg <= '{addr_high_byte: CFR_BYTE_RST,
                   muxed_addr_data_low: CFR_BYTE_RST,
                   low_oe_n: 1'b0,
                   addr_latch_en: 1'b1,
                   read_n: 1'b1};
      pend_reg <= 1'b0;
      paddr_reg <= CFR_PC_RST;
      pval_reg <= CFR_PC_RST;
    end else begin
      state_reg <= state_next;
      fetch_reg <= fetch_next;
      pc_reg <= pc_next;
      addr_reg <= addr_next;
      ir_reg <= ir_next;
      rdat_reg <= rdat_next;
      opv_reg <= opv_next;
      rdv_reg <= rdv_next;
      dec_reg <= dec_next;
      psel_reg <= psel_next;
      pair_reg <= pair_next;
      st_reg <= st_next;
      bus_reg <= bus_next;
      pend_reg <= pend_next;
      paddr_reg <= paddr_next;
      pval_reg <= pval_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ------------------------------------------------------------
  // Devices must gate selection with read_n latching of the
  // low byte by addr_latch_en is outside logic's job
  always_comb begin
    status = st_reg;
    addr_high_byte = bus_reg.addr_high_byte;
    muxed_addr_data_low = bus_reg.muxed_addr_data_low;
    low_oe_n = bus_reg.low_oe_n;
    addr_latch_en = bus_reg.addr_latch_en;
    read_n = bus_reg.read_n;
    opcode_out = ir_reg;
    opcode_valid = opv_reg;
    read_data = rdat_reg;
    read_data_valid = rdv_reg;
    first_machine_cycle = fetch_reg;
    pair_value = pval_reg;
    state_out = state_reg;
  end
endmodule

// >>> tb/cfr_fetch_read_seq_sva.sv
// Checker for the pin timing of the fetch/read sequencer
`timescale 1ns/1ps
module cfr_fetch_read_seq_sva
  import cfr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ready,
  input cfr_status_t status,
  input wire logic [7:0] addr_high_byte,
  input wire logic low_oe_n,
  input wire logic addr_latch_en,
  input wire logic read_n,
  input wire logic opcode_valid,
  input wire logic first_machine_cycle,
  input cfr_state_t state_out
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Tail of the six-state fetch
  sequence s_tail;
    state_out == CFR_T5 ##1 state_out == CFR_T6 ##1 state_out == CFR_T1;
  endsequence
  sequence s_enter_t5;
    state_out == CFR_T4 ##1 state_out == CFR_T5;
  endsequence
  property p_fetch_st;
    state_out == CFR_T1 && first_machine_cycle |-> status == CFR_ST_FETCH;
  endproperty
  a_fetch_st: assert property (p_fetch_st)
    else $error("fetch status");
  property p_read_st;
    state_out == CFR_T1 && !first_machine_cycle |-> status == CFR_ST_MREAD;
  endproperty
  a_read_st: assert property (p_read_st)
    else $error("read status");
  property p_ale;
    1'b1 |-> addr_latch_en == (state_out == CFR_T1);
  endproperty
  a_ale: assert property (p_ale) else $error("latch strobe");
  property p_float;
    state_out != CFR_T1 |-> low_oe_n;
  endproperty
  a_float: assert property (p_float)
    else $error("low byte driven");
  property p_rd;
    1'b1 |-> read_n == !(state_out inside {CFR_T2, CFR_WAIT, CFR_T3});
  endproperty
  a_rd: assert property (p_rd) else $error("read strobe");
  property p_ready;
    state_out inside {CFR_T2, CFR_WAIT} |=>
      state_out == ($past(ready) ? CFR_T3 : CFR_WAIT);
  endproperty
  a_ready: assert property (p_ready) else $error("ready step");
  property p_hold;
    state_out == CFR_WAIT |-> $stable(status) && $stable(read_n)
      && $stable(low_oe_n) && $stable(addr_high_byte);
  endproperty
  a_hold: assert property (p_hold) else $error("wait not held");
  property p_high;
    first_machine_cycle && state_out inside {CFR_T2, CFR_WAIT, CFR_T3}
      |-> $stable(addr_high_byte);
  endproperty
  a_high: assert property (p_high) else $error("high byte moved");
  property p_t3;
    state_out == CFR_T3 |=>
      state_out == ($past(first_machine_cycle) ? CFR_T4 : CFR_T1);
  endproperty
  a_t3: assert property (p_t3) else $error("after T3");
  property p_t4;
    state_out == CFR_T4 |-> opcode_valid ##1 state_out inside {CFR_T5, CFR_T1};
  endproperty
  a_t4: assert property (p_t4) else $error("after T4");
  property p_six;
    s_enter_t5 |-> s_tail;
  endproperty
  a_six: assert property (p_six) else $error("six-state fetch");
  property p_rst;
    $fell(rst) |-> state_out == CFR_T1 && read_n && first_machine_cycle;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule

bind cfr_fetch_read_seq cfr_fetch_read_seq_sva i_sva (.clock(clock),
  .rst(rst), .ready(ready), .status(status), .low_oe_n(low_oe_n),
  .addr_high_byte(addr_high_byte), .addr_latch_en(addr_latch_en),
  .read_n(read_n), .opcode_valid(opcode_valid),
  .first_machine_cycle(first_machine_cycle), .state_out(state_out));

// >>> tb/cfr_mem_model.sv
// Memory device model with address latch and wait-state control
`timescale 1ns/1ps
module cfr_mem_model (
  input wire logic clock,
  input wire logic addr_latch_en,
  input wire logic low_oe_n,
  input wire logic read_n,
  input wire logic [7:0] muxed_addr_data_low,
  input wire logic [7:0] waits,
  input wire logic [7:0] dat,
  output logic ready,
  output logic [7:0] muxed_data_in,
  output logic [7:0] latched_low
);
  logic [7:0] wcnt = 8'h00; // Clocks spent with the strobe low
  logic [7:0] last = 8'h00; // Last level seen on the data lines
  // Hold off until the chosen number of waits has passed
  assign ready = wcnt >= waits;
  // Drive only while strobed; released lines toggle so no stale byte
  assign muxed_data_in = read_n ? ~last : dat;
  // Counter, line history and low address capture
  always @(posedge clock) begin
    wcnt <= read_n ? 8'h00 : wcnt + 8'h01;
    last <= muxed_data_in;
    if (addr_latch_en && !low_oe_n) begin
      latched_low <= muxed_addr_data_low;
    end
  end
endmodule

// >>> tb/tb_cfr_fetch_read_seq.sv
// Self-checking bench for the fetch/read sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb_cfr_fetch_read_seq;
  import cfr_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ready, low_oe_n, addr_latch_en, read_n, opcode_valid;
  logic read_data_valid, first_machine_cycle, fetch;
  logic read_req = 1'b0;
  logic rq = 1'b0;
  logic [15:0] read_addr = 16'h0000;
  logic [15:0] pair_value;
  logic [7:0] muxed_data_in, addr_high_byte, muxed_addr_data_low;
  logic [7:0] opcode_out, read_data, latched_low, wc;
  logic [7:0] waits = 8'h00;
  logic [7:0] dat = 8'h00;
  cfr_status_t status;
  cfr_state_t state_out;
  int seed = 32'h7E80611F;
  int err_total = 0;
  int cmp_count = 0;
  int i;
  logic [15:0] exp_pc = CFR_PC_RST; // Address of the next fetch
  logic [15:0] exp_pair [4] = '{default: CFR_PC_RST}; // Register pairs
  // ------------------------------------------------------------
  // Instances
  // ------------------------------------------------------------
  cfr_fetch_read_seq i_cfr_fetch_read_seq (.clock(clock), .rst(rst),
    .ready(ready), .muxed_data_in(muxed_data_in), .read_req(read_req),
    .read_addr(read_addr), .status(status), .low_oe_n(low_oe_n),
    .addr_high_byte(addr_high_byte), .addr_latch_en(addr_latch_en),
    .muxed_addr_data_low(muxed_addr_data_low), .read_n(read_n),
    .opcode_out(opcode_out), .opcode_valid(opcode_valid),
    .read_data(read_data), .read_data_valid(read_data_valid),
    .first_machine_cycle(first_machine_cycle), .pair_value(pair_value),
    .state_out(state_out));
  cfr_mem_model i_cfr_mem_model (.clock(clock),
    .addr_latch_en(addr_latch_en), .low_oe_n(low_oe_n), .read_n(read_n),
    .muxed_addr_data_low(muxed_addr_data_low), .waits(waits), .dat(dat),
    .ready(ready), .muxed_data_in(muxed_data_in),
    .latched_low(latched_low));
  // 100 MHz clock
  initial begin
    forever #5 clock = ~clock;
  end
  // One cycle, then let the edge's updates settle
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  // Decrement class of opcodes takes the six-state fetch
  function automatic logic is_dec(input logic [7:0] op);
    return (op & CFR_DEC_MASK) == CFR_DEC_CODE;
  endfunction
  task automatic complete_run();
    $display("TB: checks=%0d errors=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Bounded search for the next cycle start
  task automatic seek_t1();
    int n;
    n = 0;
    while (state_out !== CFR_T1 && n < 20) begin
      step();
      n++;
    end
    if (n >= 20) begin
      err_total++;
      complete_run();
    end
  endtask
  // ------------------------------------------------------------
  // Main sequence: random fetches, queued reads and wait states
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    #1;
    `CHK(state_out, CFR_T1)
    `CHK(read_n, 1'b1)
    rst = 1'b0;
    for (i = 0; i < 300; i++) begin
      // Mid-run reset lands where the last cycle stopped (T1, or T6 after a decrement); the bus restarts at zero
      if (i == 150) begin
        rst = 1'b1;
        step();
        step();
        `CHK(state_out, CFR_T1)
        `CHK(read_n, 1'b1)
        `CHK(addr_latch_en, 1'b1)
        rst = 1'b0;
        rq = 1'b0;
        exp_pc = CFR_PC_RST;
        exp_pair = '{default: CFR_PC_RST};
      end
      seek_t1();
      fetch = first_machine_cycle;
      `CHK(fetch, !rq)
      waits = 8'($random(seed)) & 8'h03;
      // First four cycles are given the decrement opcode of each pair in turn
      dat = (i < 4) ? {2'b00, i[1:0], 4'hB} : 8'($random(seed));
      if (fetch) begin
        `CHK(status, CFR_ST_FETCH)
        `CHK({addr_high_byte, muxed_addr_data_low}, exp_pc)
        exp_pc = exp_pc + 16'h0001;
      end else begin
        `CHK(status, CFR_ST_MREAD)
        `CHK({addr_high_byte, muxed_addr_data_low}, read_addr)
      end
      `CHK(addr_latch_en, 1'b1)
      `CHK(low_oe_n, 1'b0)
      step();
      `CHK(low_oe_n, 1'b1)
      `CHK(read_n, 1'b0)
      if (!fetch) begin
        `CHK(latched_low, read_addr[7:0])
      end
      // Queue a read only while none is pending
      rq = fetch && ($random(seed) & 1);
      read_req = rq;
      if (rq) begin
        read_addr = 16'($random(seed));
      end
      wc = 8'h00;
      while (state_out !== CFR_T3 && wc < 8'h14) begin
        step();
        read_req = 1'b0;
        wc++;
      end
      `CHK(wc, waits + 8'h01)
      if (wc >= 8'h14) begin
        complete_run();
      end
      step();
      if (fetch) begin
        `CHK(state_out, CFR_T4)
        `CHK(opcode_out, dat)
        step();
        `CHK(state_out, is_dec(dat) ? CFR_T5 : CFR_T1)
        if (is_dec(dat)) begin
          exp_pair[dat[5:4]] = exp_pair[dat[5:4]] - 16'h0001;
          step();
          `CHK(state_out, CFR_T6)
          `CHK(pair_value, exp_pair[dat[5:4]])
        end
      end else begin
        `CHK(read_data_valid, 1'b1)
        `CHK(read_data, dat)
        `CHK(state_out, CFR_T1)
      end
    end
    complete_run();
  end
endmodule
